// ### design/upb_exec.v
// Execution of upper-immediate adds and PC-relative delayed and compact branches.
`timescale 1ns/1ns
`include "upb_defs.vh"
module upb_exec (
    // Clock and reset.
    input  wire        i_mclk,
    input  wire        i_rst_b,
    // Instruction from fetch and decode.
    input  wire        i_valid,
    input  wire [31:0] i_instr,
    input  wire [31:0] i_pc,
    // Register file read ports.
    output wire [4:0]  o_rs_addr,
    output wire [4:0]  o_rt_addr,
    input  wire [31:0] i_rs_data,
    input  wire [31:0] i_rt_data,
    // Register file write port.
    output reg         o_wb_en,
    output reg  [4:0]  o_wb_addr,
    output reg  [31:0] o_wb_data,
    // Program counter redirect.
    output reg         o_redirect,
    output reg  [31:0] o_redirect_pc,
    // Events.
    output reg         o_ri_exc,
    output reg  [31:0] o_exc_pc,
    output reg         o_dropped,
    output reg         o_in_slot
);
    wire [5:0]  op;
    wire [4:0]  rs;
    wire [4:0]  rt;
    wire [4:0]  sa;
    wire [5:0]  fn;
    wire [31:0] slot_pc;
    wire [31:0] link_delayed;
    wire [31:0] target16;
    wire [31:0] target26;
    wire [31:0] upper_reg;
    wire [31:0] upper_pc;

    reg         slot_pending;
    reg         slot_take;
    reg  [31:0] slot_target;
    reg         drop_next;

    reg         is_add_upper;
    reg         is_add_upper_pc;
    reg         is_eq_branch;
    reg         is_nonneg_link;
    reg         is_compact;
    reg         is_ctl_xfer;
    reg         is_delayed;
    reg         accept;
    reg         ri;
    reg         exec;

    reg         next_wb_en;
    reg  [4:0]  next_wb_addr;
    reg  [31:0] next_wb_data;
    reg         next_redirect;
    reg  [31:0] next_redirect_pc;
    reg         next_slot_pending;
    reg         next_slot_take;
    reg  [31:0] next_slot_target;
    reg         next_drop_next;

    assign op = i_instr[`UPB_OP_MSB:`UPB_OP_LSB];
    assign rs = i_instr[`UPB_RS_MSB:`UPB_RS_LSB];
    assign rt = i_instr[`UPB_RT_MSB:`UPB_RT_LSB];
    assign sa = i_instr[`UPB_SA_MSB:`UPB_SA_LSB];
    assign fn = i_instr[`UPB_FN_MSB:`UPB_FN_LSB];
    assign o_rs_addr = rs;
    assign o_rt_addr = rt;

    upb_target_calc #(
        .W              (32)
    ) u_calc (
        .i_pc           (i_pc),
        .i_rs_data      (i_rs_data),
        .i_instr        (i_instr),
        .o_slot_pc      (slot_pc),
        .o_link_delayed (link_delayed),
        .o_target16     (target16),
        .o_target26     (target26),
        .o_upper_reg    (upper_reg),
        .o_upper_pc     (upper_pc)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Decode and classification.

    always @*
    begin
        is_add_upper    = (op == `UPB_OPC_ADD_UPPER);
        is_add_upper_pc = (op == `UPB_OPC_PC_REL) && (rt == `UPB_PC_REL_ADD_UPPER);
        is_eq_branch    = (op == `UPB_OPC_EQ_BRANCH);
        is_nonneg_link  = (op == `UPB_OPC_REGIMM) && (rt == `UPB_RI_NONNEG_LINK);
        is_compact      = (op == `UPB_OPC_CJUMP) || (op == `UPB_OPC_CCALL);
        // Delayed branches and jumps own a delay slot.
        is_delayed      = ((op >= `UPB_OPC_J) && (op <= `UPB_OPC_BLEZ))
                        || ((op == `UPB_OPC_REGIMM) && ((rt == `UPB_RI_NONNEG_LINK)
                            || (rt == `UPB_RI_NAL) || (rt == `UPB_RI_BLTZ)
                            || (rt == `UPB_RI_BGEZ)))
                        || ((op == `UPB_OPC_SPECIAL)
                            && ((fn == `UPB_FN_JR) || (fn == `UPB_FN_JALR)));
        // Returns, wait and pause transfer control too, but have no slot.
        is_ctl_xfer     = is_delayed || is_compact
                        || ((op == `UPB_OPC_COP0) && i_instr[`UPB_COP0_CO_BIT]
                            && ((fn == `UPB_FN_ERET) || (fn == `UPB_FN_DERET)
                                || (fn == `UPB_FN_WAIT)))
                        || ((op == `UPB_OPC_SPECIAL) && (fn == `UPB_FN_SLL)
                            && (sa == `UPB_SA_PAUSE) && (rs == `UPB_REG_ZERO)
                            && (rt == `UPB_REG_ZERO)
                            && (i_instr[`UPB_RD_MSB:`UPB_RD_LSB] == `UPB_REG_ZERO));
        accept = i_valid && !drop_next;
        ri     = accept && ((slot_pending && is_ctl_xfer)
                 || (is_nonneg_link && (rs != `UPB_REG_ZERO)));
        exec   = accept && !ri;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state and result selection.

    always @*
    begin
        next_wb_en        = 1'b0;
        next_wb_addr      = `UPB_REG_ZERO;
        next_wb_data      = 32'h00000000;
        next_redirect     = 1'b0;
        next_redirect_pc  = o_redirect_pc;
        next_slot_pending = slot_pending;
        next_slot_take    = slot_take;
        next_slot_target  = slot_target;
        next_drop_next    = drop_next;

        if (i_valid && drop_next)
        begin
            next_drop_next = 1'b0;
        end
        else if (accept)
        begin
            next_slot_pending = 1'b0;
            next_slot_take    = 1'b0;
            // The slot has now run, so a held delayed target takes effect.
            if (slot_pending && !ri && slot_take)
            begin
                next_redirect    = 1'b1;
                next_redirect_pc = slot_target;
            end
            if (exec)
            begin
                if (is_add_upper)
                begin
                    next_wb_en   = 1'b1;
                    next_wb_addr = rt;
                    // With rs zero the register file returns zero.
                    next_wb_data = upper_reg;
                end
                else if (is_add_upper_pc)
                begin
                    next_wb_en   = 1'b1;
                    next_wb_addr = rs;
                    next_wb_data = upper_pc;
                end
                else if (is_compact)
                begin
                    next_redirect    = 1'b1;
                    next_redirect_pc = target26;
                    next_drop_next   = 1'b1;
                    if (op == `UPB_OPC_CCALL)
                    begin
                        next_wb_en   = 1'b1;
                        next_wb_addr = `UPB_REG_LINK;
                        next_wb_data = slot_pc;
                    end
                end
                if (is_delayed)
                begin
                    next_slot_pending = 1'b1;
                    next_slot_target  = target16;
                    // Register zero compared with itself is always equal.
                    next_slot_take    = (is_eq_branch && (i_rs_data == i_rt_data))
                                      || is_nonneg_link;
                end
                if (is_nonneg_link)
                begin
                    next_wb_en   = 1'b1;
                    next_wb_addr = `UPB_REG_LINK;
                    next_wb_data = link_delayed;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State and registered outputs.

    always @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            slot_pending  <= 1'b0;
            slot_take     <= 1'b0;
            slot_target   <= 32'h00000000;
            drop_next     <= 1'b0;
            o_wb_en       <= 1'b0;
            o_wb_addr     <= `UPB_REG_ZERO;
            o_wb_data     <= 32'h00000000;
            o_redirect    <= 1'b0;
            o_redirect_pc <= 32'h00000000;
            o_ri_exc      <= 1'b0;
            o_exc_pc      <= 32'h00000000;
            o_dropped     <= 1'b0;
            o_in_slot     <= 1'b0;
        end
        else
        begin
            slot_pending  <= next_slot_pending;
            slot_take     <= next_slot_take;
            slot_target   <= next_slot_target;
            drop_next     <= next_drop_next;
            o_wb_en       <= next_wb_en;
            o_wb_addr     <= next_wb_addr;
            o_wb_data     <= next_wb_data;
            o_redirect    <= next_redirect;
            o_redirect_pc <= next_redirect_pc;
            o_ri_exc      <= ri;
            o_exc_pc      <= ri ? i_pc : o_exc_pc;
            o_dropped     <= i_valid && drop_next;
            // Compact branches never set the slot flag, so nothing after them is checked.
            o_in_slot     <= next_slot_pending;
        end
    end
endmodule

// ### design/upb_defs.vh
// Constants for the upper-immediate and PC-relative branch execution block.
// Behaviour
// - Add-upper-immediate: rs plus immediate shifted left 16, result into rt.
// - Load-upper idiom is add-upper-immediate with rs zero, giving the shifted immediate.
// - Opcode 111011 with field 11110 adds shifted immediate to own address into rs.
// - Unconditional delayed branch is equal-compare branch of register zero with itself.
// - Delayed target is slot address plus offset times four; redirect after slot executes.
// - Only the nonneg-test link branch writes register 31 with branch address plus 8.
// - Control transfer executed in a delay slot raises Reserved Instruction.
// - Control transfers: branches, jumps, link-only, exception and debug returns, wait, pause.
// - Nonneg-test link branch allowed only with rs zero; otherwise Reserved Instruction.
// - Compact call links next address, jumps next address plus 26-bit offset times four.
// - A taken compact branch discards the instruction that follows it.
// - Compact branch and compact call have no forbidden slot check.
// - Compact jump target is branch address plus 4 plus offset times four.
`ifndef UPB_DEFS_VH
`define UPB_DEFS_VH

// Instruction field positions.
`define UPB_OP_MSB       31
`define UPB_OP_LSB       26
`define UPB_RS_MSB       25
`define UPB_RS_LSB       21
`define UPB_RT_MSB       20
`define UPB_RT_LSB       16
`define UPB_SA_MSB       10
`define UPB_SA_LSB       6
`define UPB_RD_MSB       15
`define UPB_RD_LSB       11
`define UPB_FN_MSB       5
`define UPB_FN_LSB       0
`define UPB_IMM_MSB      15
`define UPB_OFF26_MSB    25

// Major opcodes.
`define UPB_OPC_SPECIAL  6'h00
`define UPB_OPC_REGIMM   6'h01
`define UPB_OPC_J        6'h02
`define UPB_OPC_JAL      6'h03
`define UPB_OPC_EQ_BRANCH 6'h04
`define UPB_OPC_BLEZ     6'h07
`define UPB_OPC_COP0     6'h10
`define UPB_OPC_ADD_UPPER 6'h0F
`define UPB_OPC_CJUMP    6'h32
`define UPB_OPC_CCALL    6'h3A
`define UPB_OPC_PC_REL   6'h3B

// Minor codes.
`define UPB_PC_REL_ADD_UPPER 5'h1E
`define UPB_RI_NONNEG_LINK 5'h11
`define UPB_RI_NAL       5'h10
`define UPB_RI_BLTZ      5'h00
`define UPB_RI_BGEZ      5'h01
`define UPB_FN_JR        6'h08
`define UPB_FN_JALR      6'h09
`define UPB_FN_SLL       6'h00
`define UPB_SA_PAUSE     5'h05
`define UPB_FN_ERET      6'h18
`define UPB_FN_DERET     6'h1F
`define UPB_FN_WAIT      6'h20
`define UPB_COP0_CO_BIT  25

// Register numbers and address steps.
`define UPB_REG_ZERO     5'h00
`define UPB_REG_LINK     5'h1F
`define UPB_PC_STEP      32'h00000004
`define UPB_PC_STEP2     32'h00000008
`define UPB_UPPER_SHIFT  16
`define UPB_WORD_SHIFT   2

`endif

// ### design/upb_target_calc.v
// Address arithmetic for links, branch targets and upper-immediate sums.
`timescale 1ns/1ns
`include "upb_defs.vh"
module upb_target_calc #(
    parameter W = 32
) (
    // Operands.
    input  wire [W-1:0] i_pc,
    input  wire [W-1:0] i_rs_data,
    input  wire [31:0]  i_instr,
    // Results.
    output wire [W-1:0] o_slot_pc,
    output wire [W-1:0] o_link_delayed,
    output wire [W-1:0] o_target16,
    output wire [W-1:0] o_target26,
    output wire [W-1:0] o_upper_reg,
    output wire [W-1:0] o_upper_pc
);
    wire [15:0]  imm16;
    wire [25:0]  off26;
    wire [W-1:0] upper;
    wire [W-1:0] disp16;
    wire [W-1:0] disp26;

    assign imm16 = i_instr[`UPB_IMM_MSB:0];
    assign off26 = i_instr[`UPB_OFF26_MSB:0];
    // The shifted immediate already fills the top half, so the sign is in place.
    assign upper  = {imm16, {`UPB_UPPER_SHIFT{1'b0}}};
    assign disp16 = {{(W-18){imm16[`UPB_IMM_MSB]}}, imm16, {`UPB_WORD_SHIFT{1'b0}}};
    assign disp26 = {{(W-28){off26[`UPB_OFF26_MSB]}}, off26, {`UPB_WORD_SHIFT{1'b0}}};

    assign o_slot_pc      = i_pc + `UPB_PC_STEP;
    assign o_link_delayed = i_pc + `UPB_PC_STEP2;
    assign o_target16     = o_slot_pc + disp16;
    assign o_target26     = o_slot_pc + disp26;
    // Plain modulo additions; carry out is dropped and nothing traps.
    assign o_upper_reg    = i_rs_data + upper;
    assign o_upper_pc     = i_pc + upper;
endmodule

// ### verification/upb_gpr_model.sv
// Register file model on the far side: combinational reads, clocked write.
`timescale 1ns/1ns
module upb_gpr_model (
    input  wire        i_mclk,
    input  wire [4:0]  i_rs_addr,
    input  wire [4:0]  i_rt_addr,
    input  wire        i_wb_en,
    input  wire [4:0]  i_wb_addr,
    input  wire [31:0] i_wb_data,
    output wire [31:0] o_rs_data,
    output wire [31:0] o_rt_data
);
    reg [31:0] gpr [0:31];
    integer    k;
    initial
    begin
        for (k = 0; k < 32; k = k + 1)
            gpr[k] = 32'h01010101 * k;
    end
    // Register zero reads zero even after a write to it.
    assign o_rs_data = (i_rs_addr == 5'h00) ? 32'h00000000 : gpr[i_rs_addr];
    assign o_rt_data = (i_rt_addr == 5'h00) ? 32'h00000000 : gpr[i_rt_addr];
    always @(posedge i_mclk)
    begin
        if (i_wb_en)
            gpr[i_wb_addr] <= i_wb_data;
    end
endmodule

// ### verification/upb_exec_asserts.sv
// Port-level checks for the execution block.
`timescale 1ns/1ns
module upb_exec_asserts (
    input wire        i_mclk,
    input wire        i_rst_b,
    input wire        i_valid,
    input wire [31:0] i_instr,
    input wire [31:0] i_pc,
    input wire [31:0] i_rs_data,
    input wire        o_wb_en,
    input wire [4:0]  o_wb_addr,
    input wire [31:0] o_wb_data,
    input wire        o_redirect,
    input wire [31:0] o_redirect_pc,
    input wire        o_ri_exc,
    input wire [31:0] o_exc_pc,
    input wire        o_dropped,
    input wire        o_in_slot
);
    wire [5:0]  op  = i_instr[31:26];
    wire [31:0] up  = {i_instr[15:0], 16'h0000};
    wire [31:0] d18 = {{14{i_instr[15]}}, i_instr[15:0], 2'b00};
    wire [31:0] t26 = i_pc + 32'h00000004 + {{4{i_instr[25]}}, i_instr[25:0], 2'b00};
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    ////////////////////////////////////////
    a_upper_add_sum: assert property (i_valid && op == 6'h0F |=> o_dropped || (o_wb_en &&
        o_wb_addr == $past(i_instr[20:16]) && o_wb_data == $past(i_rs_data) + $past(up)))
        else $error("upper add result wrong");
    a_pc_upper_sum: assert property (i_valid && op == 6'h3B && i_instr[20:16] == 5'h1E
        |=> o_dropped || (o_wb_en && o_wb_data == $past(i_pc) + $past(up)))
        else $error("pc upper add result wrong");
    a_delayed_call_link: assert property (i_valid && !o_in_slot
        && i_instr[31:16] == 16'h0411
        |=> o_dropped || (o_wb_en && o_wb_addr == 5'h1F && o_wb_data == $past(i_pc) + 32'h8
        && o_in_slot && !o_redirect)) else $error("delayed call link wrong");
    a_slot_target: assert property ((i_valid && !o_in_slot && i_instr[31:16] == 16'h1000)
        ##1 (!o_dropped && i_valid && op == 6'h0F) |=> o_redirect
        && o_redirect_pc == $past(i_pc) + $past(d18, 2)) else $error("delayed target wrong");
    a_compact_call: assert property (i_valid && !o_in_slot && op == 6'h3A |=> o_dropped
        || (o_wb_en && o_wb_data == $past(i_pc) + 32'h4 && o_redirect_pc == $past(t26)))
        else $error("compact call wrong");
    a_compact_jump: assert property (i_valid && !o_in_slot && op == 6'h32 |=> o_dropped
        || (o_redirect && !o_wb_en && o_redirect_pc == $past(t26)))
        else $error("compact jump wrong");
    a_bad_link_ri: assert property (i_valid && op == 6'h01 && i_instr[20:16] == 5'h11
        && i_instr[25:21] != 5'h00 |=> o_dropped || (o_ri_exc && !o_wb_en))
        else $error("link branch not refused");
    a_slot_cti_ri: assert property (i_valid && o_in_slot && op == 6'h02
        |=> o_ri_exc && !o_redirect && o_exc_pc == $past(i_pc)) else $error("slot transfer");
    a_drop_silent: assert property (o_dropped |-> $past(i_valid) && !o_wb_en
        && !o_redirect && !o_ri_exc) else $error("dropped instruction acted");
    c_slot_redirect: cover property (o_redirect && o_wb_en);
    c_ri: cover property (o_ri_exc);
    c_drop: cover property (o_dropped);
endmodule
bind upb_exec upb_exec_asserts u_chk (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_valid(i_valid),
    .i_instr(i_instr), .i_pc(i_pc), .i_rs_data(i_rs_data), .o_wb_en(o_wb_en),
    .o_wb_addr(o_wb_addr), .o_wb_data(o_wb_data), .o_redirect(o_redirect),
    .o_redirect_pc(o_redirect_pc), .o_ri_exc(o_ri_exc), .o_exc_pc(o_exc_pc),
    .o_dropped(o_dropped), .o_in_slot(o_in_slot));

// ### verification/upb_exec_bench.sv
// Self-checking bench for the execution block with a register file model.
`timescale 1ns/1ns
module upb_exec_bench;
    reg         i_mclk;
    reg         i_rst_b;
    reg         i_valid;
    reg  [31:0] i_instr;
    reg  [31:0] i_pc;
    wire [4:0]  rs_addr;
    wire [4:0]  rt_addr;
    wire [31:0] rs_data;
    wire [31:0] rt_data;
    wire        o_wb_en;
    wire [4:0]  o_wb_addr;
    wire [31:0] o_wb_data;
    wire        o_redirect;
    wire [31:0] o_redirect_pc;
    wire        o_ri_exc;
    wire [31:0] o_exc_pc;
    wire        o_dropped;
    wire        o_in_slot;
    integer     fails;
    integer     tests_run;
    integer     n;
    reg  [31:0] xfer_op [0:6];
    upb_exec i_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_valid(i_valid), .i_instr(i_instr),
        .i_pc(i_pc), .o_rs_addr(rs_addr), .o_rt_addr(rt_addr), .i_rs_data(rs_data),
        .i_rt_data(rt_data), .o_wb_en(o_wb_en), .o_wb_addr(o_wb_addr), .o_wb_data(o_wb_data),
        .o_redirect(o_redirect), .o_redirect_pc(o_redirect_pc), .o_ri_exc(o_ri_exc),
        .o_exc_pc(o_exc_pc), .o_dropped(o_dropped), .o_in_slot(o_in_slot));
    upb_gpr_model i_gpr (.i_mclk(i_mclk), .i_rs_addr(rs_addr), .i_rt_addr(rt_addr),
        .i_wb_en(o_wb_en), .i_wb_addr(o_wb_addr), .i_wb_data(o_wb_data),
        .o_rs_data(rs_data), .o_rt_data(rt_data));
    initial i_mclk = 1'b0;
    always #10 i_mclk = ~i_mclk;
    ////////////////////////////////////////
    task chk(input [31:0] got, input [31:0] exp);
    begin
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // Outputs are looked at just after the taking edge, the cycle where they stand.
    task issue(input v, input [31:0] ins, input [31:0] pc);
    begin
        @(negedge i_mclk);
        i_valid = v;
        i_instr = ins;
        i_pc = pc;
        @(posedge i_mclk);
        #1;
    end
    endtask
    task seen(input [31:0] wb, input [31:0] ad, input [31:0] da, input [31:0] rd,
              input [31:0] ri, input [31:0] dr);
    begin
        chk(o_wb_en, wb);
        chk(o_wb_addr, ad);
        chk(o_wb_data, da);
        chk(o_redirect, rd);
        chk(o_ri_exc, ri);
        chk(o_dropped, dr);
    end
    endtask
    task results;
    begin
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    ////////////////////////////////////////
    task t_upper;
    begin
        issue(1, {6'h0F, 5'h03, 5'h05, 16'h0001}, 32'h0);
        seen(1, 5, 32'h03040303, 0, 0, 0);
        issue(1, {6'h0F, 5'h03, 5'h05, 16'hFFFF}, 32'h0);
        seen(1, 5, 32'h03020303, 0, 0, 0);
        issue(1, {6'h0F, 5'h00, 5'h06, 16'h8000}, 32'h0);
        seen(1, 6, 32'h80000000, 0, 0, 0);
        issue(1, {6'h3B, 5'h07, 5'h1E, 16'h8001}, 32'h100);
        seen(1, 7, 32'h80010100, 0, 0, 0);
        issue(1, {6'h3B, 5'h08, 5'h1E, 16'h0002}, 32'hFFFF0000);
        seen(1, 8, 32'h00010000, 0, 0, 0);
    end
    endtask
    task t_delayed;
    begin
        issue(1, {16'h1000, 16'h0003}, 32'h1000);
        seen(0, 0, 0, 0, 0, 0);
        chk(o_in_slot, 1);
        issue(1, {6'h0F, 5'h03, 5'h09, 16'h0001}, 32'h1004);
        seen(1, 9, 32'h03040303, 1, 0, 0);
        chk(o_redirect_pc, 32'h1010);
        issue(1, {16'h0411, 16'hFFFE}, 32'h2000);
        seen(1, 31, 32'h2008, 0, 0, 0);
        issue(1, 32'h0, 32'h2004);
        seen(0, 0, 0, 1, 0, 0);
        chk(o_redirect_pc, 32'h1FFC);
    end
    endtask
    task t_slot_cti;
    begin
        for (n = 0; n < 7; n = n + 1)
        begin
            issue(1, {16'h1000, 16'h0010}, 32'h3000);
            issue(1, xfer_op[n], 32'h3004);
            seen(0, 0, 0, 0, 1, 0);
            chk(o_exc_pc, 32'h3004);
        end
        issue(1, {6'h01, 5'h04, 5'h11, 16'h0004}, 32'h5000);
        seen(0, 0, 0, 0, 1, 0);
        chk(o_exc_pc, 32'h5000);
    end
    endtask
    task t_compact;
    begin
        issue(1, {6'h3A, 26'h3FFFFFF}, 32'h6000);
        seen(1, 31, 32'h6004, 1, 0, 0);
        chk(o_redirect_pc, 32'h6000);
        issue(1, 32'h08000000, 32'h6004);
        seen(0, 0, 0, 0, 0, 1);
        issue(1, {6'h32, 26'h0000005}, 32'h7000);
        seen(0, 0, 0, 1, 0, 0);
        chk(o_redirect_pc, 32'h7018);
        issue(0, 32'h0, 32'h0);
        issue(1, {6'h0F, 5'h03, 5'h0A, 16'h0001}, 32'h7004);
        seen(0, 0, 0, 0, 0, 1);
        issue(1, {6'h0F, 5'h03, 5'h0A, 16'h0001}, 32'h7018);
        seen(1, 10, 32'h03040303, 0, 0, 0);
    end
    endtask
    ////////////////////////////////////////
    initial
    begin
        fails = 0;
        tests_run = 0;
        i_rst_b = 1'b0;
        i_valid = 1'b0;
        i_instr = 32'h0;
        i_pc = 32'h0;
        xfer_op[0] = 32'h08000000;
        xfer_op[1] = 32'h04100000;
        xfer_op[2] = 32'h42000018;
        xfer_op[3] = 32'h4200001F;
        xfer_op[4] = 32'h42000020;
        xfer_op[5] = 32'h00000140;
        xfer_op[6] = 32'h00000008;
        repeat (5) @(posedge i_mclk);
        @(negedge i_mclk);
        i_rst_b = 1'b1;
        t_upper;
        t_delayed;
        t_slot_cti;
        t_compact;
        results;
    end
    // A hang is cut short here and reported as a mismatch.
    initial
    begin
        repeat (2000) @(posedge i_mclk);
        fails = fails + 1;
        results;
    end
endmodule
